// File: common/vsw_pkg.sv
// ==========================================================
// shared constants of the video switch control block
package vsw_pkg;

  // address bytes of the two variants, direction bit clear
  localparam logic [7:0] ADDR_BYTE_VAR_A = 8'h92;
  localparam logic [7:0] ADDR_BYTE_VAR_B = 8'h94;

  // control register layout
  localparam int         NUM_CTRL    = 3;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] CTRL_MASK   = 8'h70;
  localparam int         ENABLE_POS  = 6;
  localparam int         PICK_HI_POS = 5;
  localparam int         PICK_LO_POS = 4;
  localparam int         DEFAULT_POS = 6;
  localparam int         POL_HI_POS  = 5;
  localparam int         POL_LO_POS  = 4;
  localparam logic [1:0] PICK_MUTE   = 2'h0;
  localparam logic [1:0] PICK_INPUT1 = 2'h1;
  localparam logic [1:0] IDX_LIMIT   = 2'h3;

  // serial framing
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;

  // link reset pulse at a start condition
  localparam int         CLK_PERIOD_PS    = 8000;
  localparam int         LINK_HOLD_NS     = 32;
  localparam int         LINK_HOLD_CYCLES =
    (LINK_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] HOLD_LOAD = 3'(LINK_HOLD_CYCLES);

  typedef enum logic [2:0] {
    RX_ADDR   = 3'b001,
    RX_DATA   = 3'b010,
    RX_IGNORE = 3'b100
  } vsw_rx_state_t;

  // select bits of a control byte
  function automatic logic [1:0] vsw_pick(input logic [7:0] c);
    return {c[PICK_HI_POS], c[PICK_LO_POS]};
  endfunction

  // effective source of a video output, mute when disabled
  function automatic logic [1:0] vsw_route(input logic [7:0] c);
    return c[ENABLE_POS] ? vsw_pick(c) : PICK_MUTE;
  endfunction

endpackage

// File: common/vsw_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// carrier between the link receiver and the core
interface vsw_link_if;
  logic       link_hold;
  logic       wr_tog;
  logic [1:0] wr_index;
  logic [7:0] wr_byte;

  modport rx (
    input  link_hold,
    output wr_tog,
    output wr_index,
    output wr_byte
  );
  modport core (
    output link_hold,
    input  wr_tog,
    input  wr_index,
    input  wr_byte
  );
endinterface
`default_nettype wire

// File: rtl/vsw_link_rx.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// serial receiver on the bus clock, reset while out of frame
module vsw_link_rx
  import vsw_pkg::*;
#(
  parameter logic [7:0] ADDR_BYTE = ADDR_BYTE_VAR_A
) (
  input  wire logic scl_clk,
  input  wire logic sda_in,
  output logic      sda_oe_n,
  vsw_link_if.rx    link
);

  vsw_rx_state_t state, next_state;
  logic [3:0]    bit_cnt, next_bit_cnt;
  logic [7:0]    shift, next_shift;
  logic [7:0]    full_byte;
  logic          ack_pend, next_ack_pend;
  logic [1:0]    data_idx, next_data_idx;
  logic          wr_tog, next_wr_tog;
  logic [1:0]    wr_index, next_wr_index;
  logic [7:0]    wr_byte, next_wr_byte;
  logic          ack_on, next_ack_on;

  // ==========================================================
  // rising edge: shift, address match, byte hand-off
  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_ack_pend = ack_pend;
    next_data_idx = data_idx;
    next_wr_tog   = wr_tog;
    next_wr_index = wr_index;
    next_wr_byte  = wr_byte;
    full_byte     = {shift[6:0], sda_in}; // see RULE_04 see RULE_05
    if (bit_cnt != ACK_SLOT) begin
      next_shift   = full_byte;
      next_bit_cnt = bit_cnt + 4'h1;
      if (bit_cnt == LAST_DATA_BIT) begin
        case (state)
          // read direction or other address is not acknowledged
          RX_ADDR: next_ack_pend = (full_byte == ADDR_BYTE); // see RULE_01 see RULE_02 see RULE_03
          RX_DATA: next_ack_pend = (data_idx != IDX_LIMIT); // see RULE_07
          default: next_ack_pend = 1'b0;
        endcase
      end
    end else begin
      next_bit_cnt  = 4'h0;
      next_ack_pend = 1'b0;
      if (ack_pend && state == RX_DATA) begin
        next_wr_tog   = ~wr_tog; // see RULE_21
        next_wr_index = data_idx; // see RULE_08
        next_wr_byte  = shift;
        next_data_idx = data_idx + 2'h1;
      end else if (ack_pend) begin
        next_state = RX_DATA;
      end else if (state == RX_ADDR) begin
        next_state = RX_IGNORE; // see RULE_20
      end
    end
  end

  always_ff @(posedge scl_clk or posedge link.link_hold) begin
    if (link.link_hold) begin
      state    <= RX_ADDR;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      ack_pend <= 1'b0;
      data_idx <= 2'h0;
      wr_tog   <= 1'b0;
      wr_index <= 2'h0;
      wr_byte  <= 8'h00;
    end else begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      shift    <= next_shift;
      ack_pend <= next_ack_pend;
      data_idx <= next_data_idx;
      wr_tog   <= next_wr_tog;
      wr_index <= next_wr_index;
      wr_byte  <= next_wr_byte;
    end
  end

  // ==========================================================
  // falling edge: acknowledge driven for one bit time
  always_comb begin
    next_ack_on = (bit_cnt == ACK_SLOT) && ack_pend; // see RULE_04
  end

  always_ff @(negedge scl_clk or posedge link.link_hold) begin
    if (link.link_hold) begin
      ack_on <= 1'b0;
    end else begin
      ack_on <= next_ack_on;
    end
  end

  assign sda_oe_n      = ~ack_on;
  assign link.wr_tog   = wr_tog;
  assign link.wr_index = wr_index;
  assign link.wr_byte  = wr_byte;

  // ==========================================================
  // checks on the bus clock
  property p_addr_reject;
    @(posedge scl_clk) disable iff (link.link_hold)
    (state == RX_ADDR && bit_cnt == LAST_DATA_BIT && full_byte != ADDR_BYTE)
      |=> !ack_pend ##1 state == RX_IGNORE;
  endproperty
  a_addr_reject: assert property (p_addr_reject) else $error("foreign address acked"); // see RULE_20

  property p_ack_slot;
    @(posedge scl_clk) disable iff (link.link_hold)
    ack_on |-> bit_cnt == ACK_SLOT && ack_pend;
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("ack outside its slot"); // see RULE_04

  property p_data_handoff;
    @(posedge scl_clk) disable iff (link.link_hold)
    (bit_cnt == ACK_SLOT && ack_pend && state == RX_DATA)
      |=> wr_tog != $past(wr_tog) && wr_byte == $past(shift);
  endproperty
  a_data_handoff: assert property (p_data_handoff) else $error("byte not handed off"); // see RULE_21

endmodule // vsw_link_rx
`default_nettype wire

// File: rtl/vsw_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Function
// RULE_01: answer only the variant's fixed address byte
// RULE_02: first byte: seven address bits, direction
// RULE_03: write only, nothing can be read
// RULE_04: eight bits MSB first, then acknowledge
// RULE_05: sample data on clock rising edge
// RULE_06: start and stop by data edge
// RULE_07: start, address, three bytes, stop
// RULE_08: bytes fill output 0, output 1, polarity
// RULE_09: only bits 6 to 4 matter
// RULE_10: registers clear at reset, outputs muted
// RULE_11: enable bit and two-bit source select
// RULE_12: third byte: default level, two polarities
// RULE_13: detect selector follows one output's select
// RULE_14: master sets default level inverted
// RULE_15: Y/C output is XNOR with polarity
// RULE_16: input-1 flag inverts when input 1
// RULE_17: status outputs pull low or release
// RULE_18: settings persist until rewritten
// RULE_19: master keeps bus idle when possible
// RULE_20: no ack for foreign address or read
// RULE_21: byte lands after its acknowledge
module vsw_ctrl
  import vsw_pkg::*;
#(
  parameter bit VARIANT = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       yc_detect_a,
  input  wire logic       yc_detect_b,
  input  wire logic       yc_detect_c,
  output logic [1:0]      out0_route,
  output logic [1:0]      out1_route,
  output logic            yc_mode_out,
  output logic            yc_mode_oe_n,
  output logic            input1_chosen_out,
  output logic            input1_chosen_oe_n
);

  localparam logic [7:0] ADDR_BYTE =
    VARIANT ? ADDR_BYTE_VAR_B : ADDR_BYTE_VAR_A;

  vsw_link_if link ();

  // ==========================================================
  // link receiver on the bus clock
  vsw_link_rx #(
    .ADDR_BYTE (ADDR_BYTE) // see RULE_01
  ) u_rx (
    .scl_clk  (scl_clk),
    .sda_in   (sda_in),
    .sda_oe_n (sda_oe_n),
    .link     (link.rx)
  );

  // the device only ever pulls the data line low
  assign sda_out = 1'b0;

  // ==========================================================
  // synchronisers for pins and the byte toggle
  logic       scl_m, scl_s, scl_d;
  logic       sda_m, sda_s, sda_d;
  logic [2:0] det_m, det_s;
  logic       tog_m, tog_s, tog_d;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      det_m <= 3'h0;
      det_s <= 3'h0;
      tog_m <= 1'b0;
      tog_s <= 1'b0;
      tog_d <= 1'b0;
    end else begin
      scl_m <= scl_clk;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      det_m <= {yc_detect_c, yc_detect_b, yc_detect_a};
      det_s <= det_m;
      tog_m <= link.wr_tog;
      tog_s <= tog_m;
      tog_d <= tog_s;
    end
  end

  // ==========================================================
  // start and stop detection, link reset control
  logic       start_evt, stop_evt, wr_evt;
  logic       in_frame, next_in_frame;
  logic [2:0] hold_cnt, next_hold_cnt;
  logic       link_hold, next_link_hold;

  // data edges while the clock stays high
  assign start_evt = scl_s && scl_d && sda_d && !sda_s; // see RULE_06
  assign stop_evt  = scl_s && scl_d && !sda_d && sda_s; // see RULE_06
  // the receiver reset at stop or start clears its toggle; that edge is no byte
  assign wr_evt    = (tog_s ^ tog_d) && !link_hold; // see RULE_18

  always_comb begin
    next_in_frame = in_frame;
    next_hold_cnt = hold_cnt;
    if (start_evt) begin
      next_in_frame = 1'b1;
      next_hold_cnt = HOLD_LOAD; // see RULE_07
    end else if (stop_evt) begin
      next_in_frame = 1'b0;
      next_hold_cnt = 3'h0;
    end else if (hold_cnt != 3'h0) begin
      next_hold_cnt = hold_cnt - 3'h1;
    end
    // receiver held idle outside a frame and briefly at each start
    next_link_hold = !next_in_frame || (next_hold_cnt != 3'h0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_frame  <= 1'b0;
      hold_cnt  <= 3'h0;
      link_hold <= 1'b1;
    end else begin
      in_frame  <= next_in_frame;
      hold_cnt  <= next_hold_cnt;
      link_hold <= next_link_hold;
    end
  end

  assign link.link_hold = link_hold;

  // ==========================================================
  // control registers, written only by acknowledged bytes
  logic [7:0] ctrl [NUM_CTRL];
  logic [7:0] next_ctrl [NUM_CTRL];

  always_comb begin
    for (int i = 0; i < NUM_CTRL; i++) begin
      next_ctrl[i] = ctrl[i]; // see RULE_18
    end
    // byte and index are stable long before the toggle arrives
    if (wr_evt && link.wr_index != IDX_LIMIT) begin
      next_ctrl[link.wr_index] = link.wr_byte & CTRL_MASK; // see RULE_08 see RULE_09 see RULE_21
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CTRL; i++) begin
        ctrl[i] <= CTRL_RESET; // see RULE_10
      end
    end else begin
      for (int i = 0; i < NUM_CTRL; i++) begin
        ctrl[i] <= next_ctrl[i];
      end
    end
  end

  // ==========================================================
  // video output routing, one per output
  logic [1:0] route_q [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_route
      logic [1:0] next_route;
      always_comb begin
        next_route = vsw_route(ctrl[g]); // see RULE_11
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          route_q[g] <= PICK_MUTE; // see RULE_10
        end else begin
          route_q[g] <= next_route;
        end
      end
    end
  endgenerate

  assign out0_route = route_q[0];
  assign out1_route = route_q[1];

  // ==========================================================
  // detect selector and status flag logic
  logic [1:0] sel;
  logic       det_val;
  logic       yc_pol, i1_pol;
  logic       yc_mode, next_yc_mode;
  logic       in1_flag, next_in1_flag;

  always_comb begin
    sel    = vsw_pick(VARIANT ? ctrl[1] : ctrl[0]); // see RULE_13
    yc_pol = VARIANT ? ctrl[2][POL_LO_POS] : ctrl[2][POL_HI_POS]; // see RULE_12
    i1_pol = VARIANT ? ctrl[2][POL_HI_POS] : ctrl[2][POL_LO_POS]; // see RULE_12
    case (sel)
      // default level stands in when no detect input is chosen
      PICK_MUTE: det_val = ctrl[2][DEFAULT_POS]; // see RULE_13 see RULE_14
      default:   det_val = det_s[sel - 2'h1]; // see RULE_13
    endcase
    next_yc_mode  = ~(det_val ^ yc_pol); // see RULE_15
    next_in1_flag = (sel == PICK_INPUT1) ? ~i1_pol : i1_pol; // see RULE_16
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      yc_mode  <= 1'b1;
      in1_flag <= 1'b1;
    end else begin
      yc_mode  <= next_yc_mode;
      in1_flag <= next_in1_flag;
    end
  end

  // open collector: enable low pulls the line low, else released
  assign yc_mode_out        = 1'b0; // see RULE_17
  assign yc_mode_oe_n       = yc_mode; // see RULE_17
  assign input1_chosen_out  = 1'b0;
  assign input1_chosen_oe_n = in1_flag; // see RULE_17

  // ==========================================================
  // checks on the system clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_reset_mute;
    $fell(rst) |-> out0_route == PICK_MUTE && out1_route == PICK_MUTE
      ##1 ctrl[0] == CTRL_RESET || $past(wr_evt);
  endproperty
  a_reset_mute: assert property (p_reset_mute) else $error("outputs not muted after reset"); // see RULE_10

  property p_route0;
    ##1 out0_route == vsw_route($past(ctrl[0]));
  endproperty
  a_route0: assert property (p_route0) else $error("output 0 route wrong"); // see RULE_11

  property p_route1;
    ##1 out1_route == vsw_route($past(ctrl[1]));
  endproperty
  a_route1: assert property (p_route1) else $error("output 1 route wrong"); // see RULE_11

  property p_mask;
    ((ctrl[0] | ctrl[1] | ctrl[2]) & ~CTRL_MASK) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("don't-care bit stored"); // see RULE_09

  property p_persist;
    !wr_evt |=> $stable(ctrl[0]) && $stable(ctrl[1]) && $stable(ctrl[2]);
  endproperty
  a_persist: assert property (p_persist) else $error("setting changed without write"); // see RULE_18

  property p_write0;
    wr_evt && link.wr_index == 2'h0 |=> ctrl[0] == ($past(link.wr_byte) & CTRL_MASK);
  endproperty
  a_write0: assert property (p_write0) else $error("first byte not stored"); // see RULE_08

  property p_write1;
    wr_evt && link.wr_index == 2'h1 |=> ctrl[1] == ($past(link.wr_byte) & CTRL_MASK);
  endproperty
  a_write1: assert property (p_write1) else $error("second byte not stored"); // see RULE_08

  property p_write2;
    wr_evt && link.wr_index == 2'h2 |=> ctrl[2] == ($past(link.wr_byte) & CTRL_MASK);
  endproperty
  a_write2: assert property (p_write2) else $error("third byte not stored"); // see RULE_08

  property p_start_hold;
    start_evt |=> link_hold [*4] ##1 !link_hold;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("no link reset at start"); // see RULE_06

  property p_yc_mode;
    ##1 yc_mode == ~($past(det_val) ^ $past(yc_pol));
  endproperty
  a_yc_mode: assert property (p_yc_mode) else $error("yc mode output wrong"); // see RULE_15

  property p_in1_flag;
    $past(sel) == PICK_INPUT1 |-> in1_flag != $past(i1_pol);
  endproperty
  a_in1_flag: assert property (p_in1_flag) else $error("input 1 flag wrong"); // see RULE_16

  c_write_all: cover property (wr_evt && link.wr_index == 2'h2);
  c_start_stop: cover property (start_evt ##[1:1000] stop_evt);
  c_in1_sel: cover property (sel == PICK_INPUT1 && !yc_mode);
  c_out1_mute: cover property (ctrl[1][ENABLE_POS] && out1_route == PICK_MUTE);

endmodule // vsw_ctrl
`default_nettype wire

// File: verif/vsw_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// behavioural bus master driving clock and data, open drain
module vsw_bus_master #(
  parameter int QTR = 60
) (
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  // idle bus: both lines released, clock stands still
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  // data falls while clock high opens a frame
  task automatic start_cond();
    #QTR sda_rel = 1'b0;
    #(2*QTR) scl = 1'b0;
  endtask

  // eight bits msb first, then sample the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #QTR sda_rel = b[i];
      #QTR scl = 1'b1;
      #(2*QTR) scl = 1'b0;
    end
    #QTR sda_rel = 1'b1;
    #QTR scl = 1'b1;
    ack = (sda_line === 1'b0);
    #(2*QTR) scl = 1'b0;
  endtask

  // data rises while clock high closes the frame, bus left idle
  task automatic stop_cond();
    #QTR sda_rel = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_rel = 1'b1;
    #QTR;
  endtask
endmodule  // vsw_bus_master
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// self-checking bench for the video switch control block
module testbench
  import vsw_pkg::*;
;
  logic       clk;
  logic       rst;
  logic       det_a;
  logic       det_b;
  logic       det_c;
  logic       scl;
  logic       sda_rel;
  logic       sda_out;
  logic       sda_oe_n;
  logic [1:0] out0_route;
  logic [1:0] out1_route;
  logic       yc_out;
  logic       yc_oe_n;
  logic       in1_out;
  logic       in1_oe_n;
  wire        sda_line;
  int         err_total;
  int         total_checks;

  // wired data line with pull-up
  assign sda_line = sda_rel & (sda_oe_n | sda_out);

  vsw_ctrl #(
    .VARIANT (1'b0)
  ) dut_u (
    .clk                (clk),
    .rst                (rst),
    .scl_clk            (scl),
    .sda_in             (sda_line),
    .sda_out            (sda_out),
    .sda_oe_n           (sda_oe_n),
    .yc_detect_a        (det_a),
    .yc_detect_b        (det_b),
    .yc_detect_c        (det_c),
    .out0_route         (out0_route),
    .out1_route         (out1_route),
    .yc_mode_out        (yc_out),
    .yc_mode_oe_n       (yc_oe_n),
    .input1_chosen_out  (in1_out),
    .input1_chosen_oe_n (in1_oe_n)
  );

  vsw_bus_master #(
    .QTR (60)
  ) master_u (
    .sda_line (sda_line),
    .scl      (scl),
    .sda_rel  (sda_rel)
  );

  // system clock, 8 ns
  always #4 clk = ~clk;

  // ==========================================================
  // shared helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one frame of n bytes taken from the top of msg
  task automatic send_frame(input logic [39:0] msg, input int n, output logic [4:0] acks);
    logic a;
    acks = 5'h00;
    master_u.start_cond();
    for (int k = 0; k < n; k++) begin
      master_u.send_byte(msg[39-8*k -: 8], a);
      acks[4-k] = a;
    end
    master_u.stop_cond();
    repeat (12) @(negedge clk);
  endtask

  task automatic check_routes(input logic [1:0] e0, input logic [1:0] e1);
    chk("out0_route", {6'h00, e0}, {6'h00, out0_route});
    chk("out1_route", {6'h00, e1}, {6'h00, out1_route});
  endtask

  // ==========================================================
  // scenarios
  task automatic check_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check_routes(2'h0, 2'h0);
    chk("yc_mode_oe_n", 8'h01, {7'h00, yc_oe_n});
    chk("input1_chosen_oe_n", 8'h00, {7'h00, in1_oe_n});
    chk("sda_oe_n", 8'h01, {7'h00, sda_oe_n});
  endtask

  // every select code, both enables, polarity and detect levels
  task automatic status_table();
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [1:0] sel;
    logic       det;
    logic [4:0] acks;
    for (int i = 0; i < 16; i++) begin
      sel = i[1:0];
      @(negedge clk);
      det_a = i[2];
      det_b = ~i[2];
      det_c = i[3];
      c0 = {1'b1, i[3], sel, 4'h5};
      c1 = {1'b0, ~i[3], ~sel, 4'hF};
      c2 = {i[0], ~i[2], i[3], i[2] ^ i[0], 4'hA};
      send_frame({ADDR_BYTE_VAR_A, c0, c1, c2, 8'h00}, 4, acks);
      chk("acks", 8'h1E, {3'h0, acks});
      check_routes(i[3] ? sel : 2'h0, ~i[3] ? ~sel : 2'h0);
      det = (sel == 2'h0) ? c2[6] : (sel == 2'h1) ? det_a : (sel == 2'h2) ? det_b : det_c;
      chk("yc_mode_oe_n", {7'h00, ~(det ^ c2[5])}, {7'h00, yc_oe_n});
      chk("input1_chosen_oe_n", {7'h00, (sel == 2'h1) ^ c2[4]}, {7'h00, in1_oe_n});
      chk("pin drive", 8'h00, {5'h00, sda_out, yc_out, in1_out});
    end
  endtask

  // other address and read direction are refused and change nothing
  task automatic foreign_frames();
    logic [4:0] acks;
    send_frame({ADDR_BYTE_VAR_B, 8'h50, 8'h70, 8'h60, 8'h00}, 4, acks);
    chk("acks", 8'h00, {3'h0, acks});
    send_frame({ADDR_BYTE_VAR_A | 8'h01, 8'h50, 8'h70, 8'h60, 8'h00}, 4, acks);
    chk("acks", 8'h00, {3'h0, acks});
    check_routes(2'h3, 2'h0);
  endtask

  // surplus byte refused, then a frame stopped after one byte
  task automatic short_frames();
    logic [4:0] acks;
    send_frame({ADDR_BYTE_VAR_A, 8'h50, 8'h70, 8'h00, 8'hFF}, 5, acks);
    chk("acks", 8'h1E, {3'h0, acks});
    check_routes(2'h1, 2'h3);
    send_frame({ADDR_BYTE_VAR_A, 8'h60, 24'h000000}, 2, acks);
    chk("acks", 8'h18, {3'h0, acks});
    check_routes(2'h2, 2'h3);
  endtask

  // ==========================================================
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence, reset again at the end
  initial begin
    clk          = 1'b0;
    rst          = 1'b1;
    det_a        = 1'b0;
    det_b        = 1'b0;
    det_c        = 1'b0;
    err_total    = 0;
    total_checks = 0;
    check_reset();
    status_table();
    foreign_frames();
    short_frames();
    check_reset();
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    for (int n = 0; n < 100000; n++) begin
      @(posedge clk);
    end
    err_total++;
    $display("unexpected run length: expected finish, seen none");
    tally_and_finish();
  end
endmodule  // testbench
`default_nettype wire
